// >>> logic/rx_framer_defs.vh
// Constants for the receive framer and parity control block.
`ifndef RX_FRAMER_DEFS_VH
`define RX_FRAMER_DEFS_VH

// =====================================================================
// Three-level select codes
`define LVL_LOW          2'h0
`define LVL_MID          2'h1
`define LVL_HIGH         2'h2
`define LVL_BAD          2'h3

// =====================================================================
// Register offsets (byte addresses)
`define REG_CONFIG       8'h00
`define REG_STATE        8'h04
`define REG_IRQ_STATUS   8'h08
`define REG_IRQ_ENABLE   8'h0C
`define REG_IRQ_CLEAR    8'h10

// =====================================================================
// Configuration field positions and reset value
`define CFG_RXSTAT_LSB   0
`define CFG_DECODER_LSB  2
`define CFG_FRAMCHR_LSB  4
`define CFG_REFRAME_LSB  6
`define CFG_PARITY_LSB   8
`define CFG_TX_MODE_SEL_LSB   10
`define CFG_TX_CLOCK_RATE_SEL_LSB   12
`define CFG_REFRAME_ENABLE_BIT     16
`define CFG_RESET        17'h01555

// =====================================================================
// Event bits of status, enable and clear registers
`define EV_REALIGN       0
`define EV_PARITY_ERR    1
`define EV_CONFIG_ERR    2
`define EV_WIDTH         3

// =====================================================================
// Framing patterns, first received bit in the most significant place
`define K285_NEG         10'h0FA
`define K285_POS         10'h305
`define COMMA_NEG        8'h3E
`define COMMA_POS        8'hC1

// =====================================================================
// Framer timing in bits, characters and core cycles
`define MID_SPAN_BITS    50
`define CHAR_BITS        10
`define MID_SPAN_CHARS   (`MID_SPAN_BITS / `CHAR_BITS)
`define HIGH_RUN_CHARS   3'h4
`define STRETCH_CYCLES   2'h1

`endif

// >>> logic/framing_matcher.v
// One alignment lane of the framing character detector.
`timescale 1ns/100ps

module framing_matcher #(
   parameter OFFSET = 0
) (
   input  wire [19:0] history,
   input  wire        fullChar,
   output wire        hit
);
`include "rx_framer_defs.vh"

   // =================================================================
   // Candidate character

   // Shift the two-word history so this lane's character sits on top.
   wire [19:0] shifted = history << OFFSET;
   wire [9:0]  candidate = shifted[19:10];

   // =================================================================
   // Pattern compare

   // Full code group or eight-bit comma, in both disparities.
   assign hit = fullChar ?
      (candidate == `K285_NEG || candidate == `K285_POS) :
      (candidate[9:2] == `COMMA_NEG ||
       candidate[9:2] == `COMMA_POS);

endmodule

// >>> logic/rx_framer_parity_control.v
// Receive framer with parity check/generate and an AHB-Lite register file.
`timescale 1ns/100ps

module rx_framer_parity_control (
   input  wire        core_clk,
   input  wire        resetn,
   // AHB-Lite slave.
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   output wire        irq,
   // Received ten-bit words, first bit in the top place.
   input  wire [9:0]  rxWordIn,
   input  wire        rxWordValid,
   // Decoder results for the current character.
   input  wire [7:0]  rxDecodedIn,
   input  wire [2:0]  rxStatusIn,
   // Host transmit side.
   input  wire [7:0]  txDataIn,
   input  wire [1:0]  txCharType,
   input  wire        txOddParityIn,
   input  wire        txValid,
   // Receive output register, transmit parity error and reference edge phase.
   output reg  [9:0]  rxDataOut,
   output reg         rxCharValid,
   output reg  [2:0]  rxStatusBus,
   output reg         rxStatusModeAlt,
   output reg         rxOddParityOut,
   output reg         rxOddParityOe,
   output reg         txParityError,
   output reg         refEdgePhase
);
`include "rx_framer_defs.vh"

   // =================================================================
   // Register state

   reg  [16:0] cfgWord;
   reg  [2:0]  irqStatus;
   reg  [2:0]  irqEnable;
   reg  [3:0]  alignment;
   reg  [9:0]  prevWord;
   reg         configErrorSeen;
   reg         dataPhase;
   reg         dataWrite;
   reg  [7:0]  dataAddr;

   // Map a two-bit code onto a level; the spare code reads as MID.
   function [1:0] level;
      input [1:0] code;
      begin
         level = (code == `LVL_BAD) ? `LVL_MID : code;
      end
   endfunction

   // =================================================================
   // Decoded selects

   wire [1:0] rxStatSel = level(cfgWord[`CFG_RXSTAT_LSB +: 2]);
   wire [1:0] decoderSel = level(cfgWord[`CFG_DECODER_LSB +: 2]);
   wire [1:0] framCharSel = level(cfgWord[`CFG_FRAMCHR_LSB +: 2]);
   wire [1:0] reframeSel = level(cfgWord[`CFG_REFRAME_LSB +: 2]);
   wire [1:0] paritySel = level(cfgWord[`CFG_PARITY_LSB +: 2]);
   wire [1:0] txModeSel = level(cfgWord[`CFG_TX_MODE_SEL_LSB +: 2]);
   wire [1:0] txRateSel = level(cfgWord[`CFG_TX_CLOCK_RATE_SEL_LSB +: 2]);
   wire       reframeEnable = cfgWord[`CFG_REFRAME_ENABLE_BIT];
   wire       decoderBypass = (decoderSel == `LVL_LOW);
   wire       encoderBypass = (txModeSel == `LVL_LOW);
   wire       halfRate = (txRateSel == `LVL_HIGH);

   // Any spare code, or the reserved LOW framing character, is an error.
   wire configError =
      (cfgWord[1:0] == `LVL_BAD) || (cfgWord[3:2] == `LVL_BAD) ||
      (cfgWord[5:4] == `LVL_BAD) || (cfgWord[7:6] == `LVL_BAD) ||
      (cfgWord[9:8] == `LVL_BAD) || (cfgWord[11:10] == `LVL_BAD) ||
      (cfgWord[13:12] == `LVL_BAD) ||
      (framCharSel == `LVL_LOW);

   // =================================================================
   // Bus access

   wire       busReq = hsel && htrans[1] && hready;
   wire [5:0] stateWord = {decoderBypass, configError, alignment};
   wire       writeNow = dataPhase && dataWrite;
   wire       clearHit = writeNow && (dataAddr == `REG_IRQ_CLEAR);

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = |(irqStatus & irqEnable);

   // Capture the address phase and answer reads from a register.
   always @(posedge core_clk) begin
      if (!resetn) begin
         dataPhase <= 1'b0;
         dataWrite <= 1'b0;
         dataAddr <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         dataPhase <= busReq;
         dataWrite <= busReq && hwrite;
         dataAddr <= haddr;
         if (busReq && !hwrite) begin
            case (haddr)
               `REG_CONFIG:     hrdata <= {15'h0000, cfgWord};
               `REG_STATE:      hrdata <= {26'h0000000, stateWord};
               `REG_IRQ_STATUS: hrdata <= {29'h00000000, irqStatus};
               `REG_IRQ_ENABLE: hrdata <= {29'h00000000, irqEnable};
               default:         hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Store writes during the data phase.
   always @(posedge core_clk) begin
      if (!resetn) begin
         cfgWord <= `CFG_RESET;
         irqEnable <= 3'h0;
      end else if (writeNow) begin
         if (dataAddr == `REG_CONFIG)
            cfgWord <= hwdata[16:0];
         if (dataAddr == `REG_IRQ_ENABLE)
            irqEnable <= hwdata[2:0];
      end
   end

   // =================================================================
   // Framing character detection

   wire [19:0] history = {prevWord, rxWordIn};
   wire [9:0]  hits;
   wire        fullChar = (framCharSel == `LVL_HIGH);

   genvar g;
   generate
      for (g = 0; g < 10; g = g + 1) begin : lane
         framing_matcher #(
            .OFFSET   (g)
         ) matcher (
            .history  (history),
            .fullChar (fullChar),
            .hit      (hits[g])
         );
      end
   endgenerate

   // Pick the earliest alignment that holds a framing character.
   reg [3:0] hitOffset;
   integer   i;
   always @* begin
      hitOffset = 4'h0;
      for (i = 9; i >= 0; i = i - 1) begin
         if (hits[i])
            hitOffset = i[3:0];
      end
   end

   wire anyHit = |hits;

   // =================================================================
   // Reframe control

   reg  [2:0] midGap;
   reg        midArmed;
   reg  [3:0] candOffset;
   reg  [2:0] runCount;
   reg  [3:0] runOffset;
   reg  [1:0] stretchCount;
   reg        next_realign;
   reg  [3:0] next_alignment;

   // Decide whether this word commits a new boundary.
   always @* begin
      next_realign = 1'b0;
      next_alignment = alignment;
      if (rxWordValid && reframeEnable && anyHit) begin
         case (reframeSel)
            `LVL_LOW:
               next_realign = 1'b1;
            `LVL_MID:
               next_realign = midArmed && hitOffset == candOffset &&
                  midGap < `MID_SPAN_CHARS;
            `LVL_HIGH:
               next_realign = hitOffset == runOffset &&
                  runCount == `HIGH_RUN_CHARS - 3'h1;
            default:
               next_realign = 1'b0;
         endcase
         if (next_realign)
            next_alignment = hitOffset;
      end
   end

   wire boundaryMoved = next_realign && (next_alignment != alignment);

   // Track candidate hits for the multi-character framers.
   always @(posedge core_clk) begin
      if (!resetn) begin
         midGap <= 3'h0;
         midArmed <= 1'b0;
         candOffset <= 4'h0;
         runCount <= 3'h0;
         runOffset <= 4'h0;
         alignment <= 4'h0;
         prevWord <= 10'h000;
      end else if (rxWordValid) begin
         prevWord <= rxWordIn;
         alignment <= next_alignment;
         if (!reframeEnable) begin
            midArmed <= 1'b0;
            runCount <= 3'h0;
         end else if (anyHit) begin
            midArmed <= 1'b1;
            candOffset <= hitOffset;
            midGap <= 3'h1;
            if (hitOffset == runOffset && runCount != 3'h0 &&
                runCount != `HIGH_RUN_CHARS)
               runCount <= runCount + 3'h1;
            else if (hitOffset != runOffset || runCount == 3'h0)
               runCount <= 3'h1;
            runOffset <= hitOffset;
         end else begin
            runCount <= 3'h0;
            midGap <= midGap + 3'h1;
            if (midGap >= `MID_SPAN_CHARS - 1)
               midArmed <= 1'b0;
         end
      end
   end

   // =================================================================
   // Output register and character clock

   wire [19:0] aligned = history << alignment;
   wire [9:0]  framedChar = aligned[19:10];
   wire [9:0]  next_rxData = decoderBypass ?
      framedChar : {2'h0, rxDecodedIn};
   wire        next_parity = (paritySel == `LVL_HIGH) ?
      ~^{next_rxData[7:0], rxStatusIn} :
      ~^next_rxData[7:0];

   // Present characters; a low-latency shift drops the strobe for two cycles.
   always @(posedge core_clk) begin
      if (!resetn) begin
         rxDataOut <= 10'h000;
         rxCharValid <= 1'b0;
         rxStatusBus <= 3'h0;
         rxStatusModeAlt <= 1'b0;
         rxOddParityOut <= 1'b0;
         rxOddParityOe <= 1'b0;
         stretchCount <= 2'h0;
      end else begin
         rxStatusModeAlt <= !decoderBypass &&
            rxStatSel == `LVL_HIGH;
         rxOddParityOe <= (paritySel != `LVL_LOW);
         if (boundaryMoved && reframeSel == `LVL_LOW)
            stretchCount <= `STRETCH_CYCLES;
         else if (stretchCount != 2'h0)
            stretchCount <= stretchCount - 2'h1;
         rxCharValid <= rxWordValid && stretchCount == 2'h0 &&
            !(boundaryMoved && reframeSel == `LVL_LOW);
         if (rxWordValid) begin
            rxDataOut <= next_rxData;
            rxStatusBus <= rxStatusIn;
            rxOddParityOut <= next_parity;
         end
      end
   end

   // =================================================================
   // Transmit parity check

   wire txSample = txValid && (halfRate || !refEdgePhase);
   wire codecsOff = encoderBypass && decoderBypass;
   wire withType = (paritySel == `LVL_HIGH) ||
      (paritySel == `LVL_MID && codecsOff);
   wire txOdd = withType ?
      ^{txDataIn, txCharType, txOddParityIn} :
      ^{txDataIn, txOddParityIn};
   wire parityBad = txSample && paritySel != `LVL_LOW && !txOdd;

   // Half-rate input sampling treats each core cycle as a reference edge.
   always @(posedge core_clk) begin
      if (!resetn) begin
         refEdgePhase <= 1'b0;
         txParityError <= 1'b0;
      end else begin
         refEdgePhase <= !refEdgePhase;
         txParityError <= parityBad;
      end
   end

   // =================================================================
   // Interrupt status

   wire [2:0] events;
   assign events[`EV_REALIGN] = boundaryMoved;
   assign events[`EV_PARITY_ERR] = parityBad;
   assign events[`EV_CONFIG_ERR] = configError && !configErrorSeen;

   // Sticky bits; a new event wins over a clear in the same cycle.
   always @(posedge core_clk) begin
      if (!resetn) begin
         irqStatus <= 3'h0;
         configErrorSeen <= 1'b0;
      end else begin
         configErrorSeen <= configError;
         irqStatus <= (irqStatus & ~(clearHit ? hwdata[2:0] : 3'h0)) |
            events;
      end
   end

endmodule

// >>> tb/rx_framer_monitor.sv
// Port checker for the receive framer and parity block.
`timescale 1ns/100ps

module rx_framer_monitor (
   input wire        core_clk,
   input wire        resetn,
   input wire        irq,
   input wire        rxWordValid,
   input wire [7:0]  rxDecodedIn,
   input wire [2:0]  rxStatusIn,
   input wire        txValid,
   input wire [9:0]  rxDataOut,
   input wire        rxCharValid,
   input wire [2:0]  rxStatusBus,
   input wire        rxStatusModeAlt,
   input wire        txParityError,
   input wire        refEdgePhase
);
   // ====================
   // Clocking and reset.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // ====================
   // Port relations.
   a_strobe_cause:
      assert property (rxCharValid |-> $past(rxWordValid))
      else $error("Character strobe without a received word.");
   a_err_cause:
      assert property (txParityError |-> $past(txValid))
      else $error("Parity error without a transmit character.");
   a_phase_toggle:
      assert property ($past(resetn) |-> refEdgePhase != $past(refEdgePhase))
      else $error("Edge phase did not alternate.");
   a_data_hold:
      assert property (!rxWordValid |=> $stable(rxDataOut))
      else $error("Output character changed without a word.");
   a_status_hold:
      assert property (!rxWordValid |=> $stable(rxStatusBus))
      else $error("Status bus changed without a word.");
   a_status_copy:
      assert property (rxWordValid |=> rxStatusBus == $past(rxStatusIn))
      else $error("Status bus is not the decoder status.");
   a_decoded_path:
      assert property (rxWordValid && rxStatusModeAlt
                       |=> rxDataOut == {2'h0, $past(rxDecodedIn)})
      else $error("Decoded character not presented.");
   a_reset_quiet:
      assert property ($rose(resetn) |-> !irq && !rxCharValid && !txParityError)
      else $error("Outputs active right after reset.");
endmodule

bind rx_framer_parity_control rx_framer_monitor rx_framer_monitor_i (
   .core_clk(core_clk), .resetn(resetn), .irq(irq),
   .rxWordValid(rxWordValid), .rxDecodedIn(rxDecodedIn),
   .rxStatusIn(rxStatusIn), .txValid(txValid), .rxDataOut(rxDataOut),
   .rxCharValid(rxCharValid), .rxStatusBus(rxStatusBus),
   .rxStatusModeAlt(rxStatusModeAlt), .txParityError(txParityError),
   .refEdgePhase(refEdgePhase));

// >>> tb/host_char_model.sv
// Host model that presents transmit characters with odd parity.
`timescale 1ns/100ps

module host_char_model (
   input  wire       core_clk,
   input  wire       sendGo,
   input  wire [7:0] sendData,
   input  wire [1:0] sendType,
   input  wire       sendBad,
   input  wire       withType,
   output reg  [7:0] txDataIn,
   output reg  [1:0] txCharType,
   output reg        txOddParityIn,
   output reg        txValid
);
   wire [1:0] typePart = sendType & {2{withType}};

   // Lines start low so the block never sees unknown inputs.
   initial begin
      txDataIn = 8'h00;
      txCharType = 2'h0;
      txOddParityIn = 1'b0;
      txValid = 1'b0;
   end

   // One character per core edge; idle lines show inverted history.
   always @(posedge core_clk) begin
      txValid <= sendGo;
      if (sendGo) begin
         txDataIn <= sendData;
         txCharType <= sendType;
         txOddParityIn <= ~^{sendData, typePart} ^ sendBad;
      end else begin
         txDataIn <= ~txDataIn;
         txCharType <= ~txCharType;
         txOddParityIn <= ~txOddParityIn;
      end
   end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the receive framer and parity block.
`timescale 1ns/100ps

module testbench;
   // ====================
   // Signals.
   typedef struct packed {
      logic [31:0] cfg;
      logic [7:0]  dec;
      logic [2:0]  st;
      logic [7:0]  txd;
      logic [1:0]  typ;
      logic [1:0]  md;
      logic [9:0]  data;
      logic [3:0]  res;
   } row_t;
   reg         core_clk = 1'b0;
   reg         resetn = 1'b0;
   reg         hsel = 1'b0;
   reg         hwrite = 1'b0;
   reg  [7:0]  haddr = 8'h00;
   reg  [1:0]  htrans = 2'h0;
   reg  [31:0] hwdata = 32'h0;
   reg  [9:0]  rxWordIn = 10'h000;
   reg         rxWordValid = 1'b0;
   reg  [7:0]  rxDecodedIn = 8'h00;
   reg  [2:0]  rxStatusIn = 3'h0;
   reg         sendGo = 1'b0;
   reg         sendBad = 1'b0;
   reg         withType = 1'b0;
   reg  [7:0]  sendData = 8'h00;
   reg  [1:0]  sendType = 2'h0;
   wire        hready, hresp, irq, rxCharValid, rxStatusModeAlt;
   wire        rxOddParityOut, rxOddParityOe, txParityError;
   wire        refEdgePhase, txOddParityIn, txValid;
   wire [31:0] hrdata;
   wire [9:0]  rxDataOut;
   wire [2:0]  rxStatusBus;
   wire [7:0]  txDataIn;
   wire [1:0]  txCharType;
   integer     n_errors = 0;
   integer     samples_checked = 0;
   integer     cycles = 0;
   integer     strobes = 0;
   integer     errPulses = 0;
   integer     i;
   reg  [31:0] q;
   // Result nibble: parity, output enable, alternate status, tx error.
   row_t rows [7] = '{
      '{32'h2555, 8'h01, 3'h7, 8'h03, 2'h0, 2'h0, 10'h001, 4'h4},
      '{32'h2555, 8'h00, 3'h0, 8'h03, 2'h3, 2'h2, 10'h000, 4'hD},
      '{32'h2655, 8'h01, 3'h1, 8'h01, 2'h1, 2'h1, 10'h001, 4'hC},
      '{32'h2455, 8'h00, 3'h0, 8'h00, 2'h0, 2'h2, 10'h000, 4'h0},
      '{32'h2151, 8'hFF, 3'h0, 8'h01, 2'h1, 2'h0, 10'h001, 4'h5},
      '{32'h2556, 8'h01, 3'h0, 8'h03, 2'h0, 2'h0, 10'h001, 4'h6},
      '{32'h2152, 8'hFF, 3'h0, 8'h01, 2'h0, 2'h0, 10'h001, 4'h4}};

   rx_framer_parity_control rx_framer_parity_control_i (
      .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .irq(irq), .rxWordIn(rxWordIn), .rxWordValid(rxWordValid),
      .rxDecodedIn(rxDecodedIn), .rxStatusIn(rxStatusIn),
      .txDataIn(txDataIn), .txCharType(txCharType),
      .txOddParityIn(txOddParityIn), .txValid(txValid),
      .rxDataOut(rxDataOut), .rxCharValid(rxCharValid),
      .rxStatusBus(rxStatusBus), .rxStatusModeAlt(rxStatusModeAlt),
      .rxOddParityOut(rxOddParityOut), .rxOddParityOe(rxOddParityOe),
      .txParityError(txParityError), .refEdgePhase(refEdgePhase));

   host_char_model host_char_model_i (
      .core_clk(core_clk), .sendGo(sendGo), .sendData(sendData),
      .sendType(sendType), .sendBad(sendBad), .withType(withType),
      .txDataIn(txDataIn), .txCharType(txCharType),
      .txOddParityIn(txOddParityIn), .txValid(txValid));

   // ====================
   // Clock, pulse counters and hang guard.
   initial begin
      forever #5 core_clk = ~core_clk;
   end

   // Counts strobes and error pulses; a hung run is cut short here.
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (rxCharValid) strobes = strobes + 1;
      if (txParityError) errPulses = errPulses + 1;
      if (cycles == 4000) begin
         n_errors = n_errors + 1;
         stop_test;
      end
   end

   // ====================
   // Tasks.
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task check(input [31:0] got, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task do_reset(input integer n);
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (n) @(posedge core_clk);
      resetn <= 1'b1;
   endtask

   task xfer(input w, input [7:0] a, input [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge core_clk);
      while (!hready) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk);
      while (!hready) @(posedge core_clk);
      q = hrdata;
      check(hresp, 1'b0);
      #1;
   endtask

   task words(input [59:0] v, input integer n);
      integer k;
      for (k = 0; k < n; k = k + 1) begin
         @(posedge core_clk);
         rxWordIn <= v[10*(n-1-k) +: 10];
         rxWordValid <= 1'b1;
      end
      @(posedge core_clk);
      rxWordValid <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   task txburst(input integer n);
      errPulses = 0;
      @(posedge core_clk);
      sendGo <= 1'b1;
      sendBad <= 1'b1;
      repeat (n) @(posedge core_clk);
      sendGo <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
   endtask

   task align(input [3:0] exp);
      xfer(1'b0, 8'h04, 32'h0);
      check(q[3:0], exp);
   endtask

   // ====================
   // Main sequence.
   initial begin
      do_reset(20);
      xfer(1'b0, 8'h00, 32'h0);
      check(q, 32'h01555);
      xfer(1'b0, 8'h20, 32'h0);
      check(q, 32'h0);
      align(4'h0);
      $display("test reset done");
      for (i = 0; i < 7; i = i + 1) begin
         xfer(1'b1, 8'h00, rows[i].cfg);
         @(posedge core_clk);
         rxDecodedIn <= rows[i].dec;
         rxStatusIn <= rows[i].st;
         rxWordIn <= 10'h001;
         rxWordValid <= 1'b1;
         sendGo <= 1'b1;
         sendData <= rows[i].txd;
         sendType <= rows[i].typ;
         {sendBad, withType} <= rows[i].md;
         @(posedge core_clk);
         rxWordValid <= 1'b0;
         sendGo <= 1'b0;
         #1;
         check(rxDataOut, rows[i].data);
         check(rxOddParityOe, rows[i].res[2]);
         check(rxStatusModeAlt, rows[i].res[1]);
         if (rows[i].res[2]) check(rxOddParityOut, rows[i].res[3]);
         @(posedge core_clk);
         #1;
         check(txParityError, rows[i].res[0]);
      end
      xfer(1'b0, 8'h08, 32'h0);
      check(q[1], 1'b1);
      $display("test table done");
      for (i = 0; i < 2; i = i + 1) begin
         do_reset(1);
         xfer(1'b1, 8'h00, i ? 32'h1545 : 32'h1755);
         xfer(1'b0, 8'h04, 32'h0);
         check(q[4], 1'b1);
      end
      $display("test flags done");
      do_reset(1);
      xfer(1'b1, 8'h0C, 32'h1);
      xfer(1'b1, 8'h00, 32'h2525);
      words({10'h01F, 10'h100, 20'h0}, 4);
      align(4'h0);
      xfer(1'b1, 8'h00, 32'h12525);
      strobes = 0;
      words({10'h01F, 10'h100, 20'h0}, 4);
      check(strobes, 2);
      align(4'h3);
      check(irq, 1'b1);
      xfer(1'b1, 8'h0C, 32'h0);
      check(irq, 1'b0);
      xfer(1'b1, 8'h0C, 32'h1);
      xfer(1'b1, 8'h10, 32'h1);
      check(irq, 1'b0);
      words({10'h018, 10'h0A0, 20'h0}, 4);
      align(4'h5);
      xfer(1'b1, 8'h00, 32'h12515);
      words({10'h03E, 10'h000}, 2);
      align(4'h2);
      $display("test low latency done");
      do_reset(1);
      xfer(1'b1, 8'h00, 32'h12565);
      words({10'h01F, 10'h100, 40'h0}, 6);
      align(4'h0);
      strobes = 0;
      words({10'h01F, 10'h100, 10'h01F, 10'h100}, 4);
      check(strobes, 4);
      align(4'h3);
      do_reset(1);
      xfer(1'b1, 8'h00, 32'h125A5);
      words({4{10'h11F}}, 4);
      align(4'h0);
      words(60'h11F, 1);
      align(4'h3);
      $display("test multi byte done");
      do_reset(1);
      txburst(2);
      check(errPulses, 1);
      xfer(1'b1, 8'h00, 32'h2555);
      txburst(2);
      check(errPulses, 2);
      $display("test clock rate done");
      stop_test;
   end
endmodule
